// ### ddcf_map.svh
`ifndef DDCF_MAP_SVH
`define DDCF_MAP_SVH
// Register offsets
`define DDCF_A_SYNC 9'h100
`define DDCF_A_FIR 9'h102
`define DDCF_A_HB 9'h103
`define DDCF_A_SHIFT 9'h1F0
`define DDCF_A_STAT 9'h1F1
// Field positions
`define DDCF_B_SYNC_EN 5
`define DDCF_B_SYNC_ONCE 6
`define DDCF_B_FIR_EN 0
`define DDCF_B_DEC_PH 3
`define DDCF_B_SHIFT_EN 0
// Reset value of every control bit
`define DDCF_RST_BIT 1'b0
// Filter geometry, scaling and FIFO depth
`define DDCF_HB_TAPS 19
`define DDCF_FIR_TAPS 66
`define DDCF_HB_SCALE 19
`define DDCF_FIR_SCALE 21
`define DDCF_FIFO_DEPTH 4
`endif

// ### ddcf_pkg.sv
package ddcf_pkg;
	typedef logic signed [15:0] ddcf_smp_t;
	typedef struct packed {
		ddcf_smp_t i;
		ddcf_smp_t q;
	} ddcf_iq_s;
	typedef struct packed {
		logic is_q;
		ddcf_smp_t data;
	} ddcf_word_s;
	typedef enum logic [3:0] {
		DDCF_ST_IDLE = 4'h1,
		DDCF_ST_HB = 4'h2,
		DDCF_ST_FIR = 4'h4,
		DDCF_ST_PUSH = 4'h8
	} ddcf_state_e;

	function automatic int ddcf_hb_coef(input int k);
		int d;
		d = (k < 9) ? k : 18 - k;
		case (d)
			0: return 844;
			2: return -6189;
			4: return 25080;
			6: return -79170;
			8: return 321584;
			9: return 524287;
			default: return 0;
		endcase
	endfunction : ddcf_hb_coef

	// Mirror index: coefficient n equals coefficient 65 - n
	function automatic int ddcf_fir_coef(input int k);
		int d;
		d = (k < 33) ? k : 65 - k;
		case (d)
			0: return 383; 1: return 1431; 2: return 1950; 3: return 96;
			4: return -2661; 5: return -1750; 6: return 2476; 7: return 2388;
			8: return -3867; 9: return -5150; 10: return 3788; 11: return 7513;
			12: return -4511; 13: return -11914; 14: return 3650; 15: return 16484;
			16: return -2818; 17: return -23200; 18: return -48; 19: return 30748;
			20: return 3976; 21: return -41019; 22: return -11147; 23: return 53608;
			24: return 21818; 25: return -71611; 26: return -40300; 27: return 98830;
			28: return 74264; 29: return -152696; 30: return -161248; 31: return 337056;
			default: return 922060;
		endcase
	endfunction : ddcf_fir_coef
endpackage : ddcf_pkg

// ### ddcf_top.sv
// Function
// - FIR stage follows half-band decimator, 66 taps
// - Sum of products, 21-bit signed coefficients
// - One FIR output per input, no decimation
// - Bit 0 of 0x102 low bypasses FIR
// - FIR only filters half-band output samples
// - Symmetric coefficients, outer 383, centre 922060
// - Sync every strobe or first after write
// - Accepted strobe restarts decimation at programmed phase
// - I and Q both filtered through stages
// - Final shift moves signal to ADC/8
// - Shift bypassed: I and Q interleaved
// - Half-band: 19-tap symmetric, decimate by two
// - Bit 3 of 0x103 picks decimation phase
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ddcf_map.svh"

module ddcf_fifo #(
	parameter int W = 17,
	parameter int DEPTH = `DDCF_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ddcf_fifo depth must be a power of two");
	end
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
	logic full, empty;
	always_comb begin
		full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
		empty = (wp_reg == rp_reg);
		in_ready = ce && !full;
		out_valid = ce && !empty;
		out_data = mem_reg[rp_reg[AW-1:0]];
		wp_next = wp_reg + ((in_valid && in_ready) ? 1'b1 : 1'b0);
		rp_next = rp_reg + ((out_valid && out_ready) ? 1'b1 : 1'b0);
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else if (ce) begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
		end
	end
	// Storage has no reset; empty flag hides its content
	always_ff @(posedge clk_sys) begin
		if (ce && in_valid && in_ready) begin
			mem_reg[wp_reg[AW-1:0]] <= in_data;
		end
	end
endmodule : ddcf_fifo

module ddcf_top #(
	parameter int DATA_W = 16,
	parameter int FIFO_DEPTH = `DDCF_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// Complex input from tuning oscillator
	input wire logic in_valid,
	output logic in_ready,
	input wire ddcf_pkg::ddcf_iq_s in_iq,
	// Alignment strobe
	input wire logic sync_in,
	// Output stream
	output logic out_valid,
	input wire logic out_ready,
	output ddcf_pkg::ddcf_word_s out_word
);
	localparam int HB_N = `DDCF_HB_TAPS;
	localparam int FIR_N = `DDCF_FIR_TAPS;
	if (DATA_W != $bits(ddcf_pkg::ddcf_smp_t)) begin : g_bad_width
		$error("ddcf_top DATA_W must match the package sample width");
	end
	function automatic ddcf_pkg::ddcf_smp_t sat(input logic signed [47:0] v);
		if (v > 48'sh7FFF) return 16'sh7FFF;
		if (v < -48'sh8000) return -16'sh8000;
		return v[15:0];
	endfunction : sat
	// Control registers
	logic sync_en_reg, sync_en_next, once_reg, once_next, armed_reg, armed_next;
	logic fir_en_reg, fir_en_next, dec_ph_reg, dec_ph_next, shift_en_reg, shift_en_next;
	logic [7:0] rdata_next;
	logic sync_ok;
	// Datapath state
	ddcf_pkg::ddcf_state_e st_reg, st_next;
	ddcf_pkg::ddcf_iq_s hb_line_reg [HB_N], hb_line_next [HB_N];
	ddcf_pkg::ddcf_iq_s fir_line_reg [FIR_N], fir_line_next [FIR_N];
	ddcf_pkg::ddcf_iq_s byp_reg, byp_next, res_reg, res_next, hb_val;
	logic cnt_reg, cnt_next, cnt_cur, wsel_reg, wsel_next, accept;
	logic [1:0] step_reg, step_next;
	logic signed [47:0] hb_acc_i, hb_acc_q, fir_acc_i, fir_acc_q;
	ddcf_pkg::ddcf_word_s push_word;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
	// Write to 0x100 arms; a strobe taken in the same cycle loses to it
	always_comb begin
		sync_ok = sync_in && sync_en_reg && (!once_reg || armed_reg);
		sync_en_next = sync_en_reg;
		once_next = once_reg;
		fir_en_next = fir_en_reg;
		dec_ph_next = dec_ph_reg;
		shift_en_next = shift_en_reg;
		armed_next = armed_reg;
		if (sync_ok && once_reg) begin
			armed_next = 1'b0;
		end
		if (reg_we) begin
			unique case (reg_addr)
				`DDCF_A_SYNC: begin
					sync_en_next = reg_wdata[`DDCF_B_SYNC_EN];
					once_next = reg_wdata[`DDCF_B_SYNC_ONCE];
					armed_next = 1'b1;
				end
				`DDCF_A_FIR: fir_en_next = reg_wdata[`DDCF_B_FIR_EN];
				`DDCF_A_HB: dec_ph_next = reg_wdata[`DDCF_B_DEC_PH];
				`DDCF_A_SHIFT: shift_en_next = reg_wdata[`DDCF_B_SHIFT_EN];
				default: ;
			endcase
		end
		rdata_next = 8'h00;
		if (reg_re) begin
			unique case (reg_addr)
				`DDCF_A_SYNC: begin
					rdata_next[`DDCF_B_SYNC_EN] = sync_en_reg;
					rdata_next[`DDCF_B_SYNC_ONCE] = once_reg;
				end
				`DDCF_A_FIR: rdata_next[`DDCF_B_FIR_EN] = fir_en_reg;
				`DDCF_A_HB: rdata_next[`DDCF_B_DEC_PH] = dec_ph_reg;
				`DDCF_A_SHIFT: rdata_next[`DDCF_B_SHIFT_EN] = shift_en_reg;
				`DDCF_A_STAT: rdata_next = {3'h0, fifo_out_valid, step_reg, cnt_reg, armed_reg};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_en_reg <= `DDCF_RST_BIT;
			once_reg <= `DDCF_RST_BIT;
			armed_reg <= `DDCF_RST_BIT;
			fir_en_reg <= `DDCF_RST_BIT;
			dec_ph_reg <= `DDCF_RST_BIT;
			shift_en_reg <= `DDCF_RST_BIT;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			sync_en_reg <= sync_en_next;
			once_reg <= once_next;
			armed_reg <= armed_next;
			fir_en_reg <= fir_en_next;
			dec_ph_reg <= dec_ph_next;
			shift_en_reg <= shift_en_next;
			reg_rdata <= rdata_next;
		end
	end

	// Both paths run through identical sums of products
	always_comb begin
		hb_acc_i = '0;
		hb_acc_q = '0;
		for (int k = 0; k < HB_N; k++) begin
			hb_acc_i += 48'(hb_line_reg[k].i) * 48'(ddcf_pkg::ddcf_hb_coef(k));
			hb_acc_q += 48'(hb_line_reg[k].q) * 48'(ddcf_pkg::ddcf_hb_coef(k));
		end
		fir_acc_i = '0;
		fir_acc_q = '0;
		for (int k = 0; k < FIR_N; k++) begin
			fir_acc_i += 48'(fir_line_reg[k].i) * 48'(ddcf_pkg::ddcf_fir_coef(k));
			fir_acc_q += 48'(fir_line_reg[k].q) * 48'(ddcf_pkg::ddcf_fir_coef(k));
		end
		hb_val.i = sat(hb_acc_i >>> `DDCF_HB_SCALE);
		hb_val.q = sat(hb_acc_q >>> `DDCF_HB_SCALE);
	end

	// One sample in flight; input waits until its words reach the FIFO
	always_comb begin
		st_next = st_reg;
		hb_line_next = hb_line_reg;
		fir_line_next = fir_line_reg;
		byp_next = byp_reg;
		res_next = res_reg;
		wsel_next = wsel_reg;
		step_next = step_reg;
		in_ready = ce && (st_reg == ddcf_pkg::DDCF_ST_IDLE);
		accept = in_valid && in_ready;
		cnt_cur = sync_ok ? !dec_ph_reg : cnt_reg;
		cnt_next = cnt_cur;
		if (sync_ok) begin
			step_next = 2'h0;
		end
		push_word = '0;
		fifo_in_valid = 1'b0;
		unique case (st_reg)
			ddcf_pkg::DDCF_ST_IDLE: begin
				if (accept) begin
					hb_line_next[0] = in_iq;
					for (int k = 1; k < HB_N; k++) hb_line_next[k] = hb_line_reg[k-1];
					cnt_next = !cnt_cur;
					if (cnt_cur) st_next = ddcf_pkg::DDCF_ST_HB;
				end
			end
			ddcf_pkg::DDCF_ST_HB: begin
				// Disabled FIR line stays still to save power
				if (fir_en_reg) begin
					fir_line_next[0] = hb_val;
					for (int k = 1; k < FIR_N; k++) fir_line_next[k] = fir_line_reg[k-1];
				end else begin
					byp_next = hb_val;
				end
				st_next = ddcf_pkg::DDCF_ST_FIR;
			end
			ddcf_pkg::DDCF_ST_FIR: begin
				if (fir_en_reg) begin
					res_next.i = sat(fir_acc_i >>> `DDCF_FIR_SCALE);
					res_next.q = sat(fir_acc_q >>> `DDCF_FIR_SCALE);
				end else begin
					res_next = byp_reg;
				end
				wsel_next = 1'b0;
				st_next = ddcf_pkg::DDCF_ST_PUSH;
			end
			ddcf_pkg::DDCF_ST_PUSH: begin
				fifo_in_valid = 1'b1;
				if (shift_en_reg) begin
					// Most negative value clips on negation
					unique case (step_reg)
						2'h0: push_word.data = res_reg.i;
						2'h1: push_word.data = sat(-48'(res_reg.q));
						2'h2: push_word.data = sat(-48'(res_reg.i));
						2'h3: push_word.data = res_reg.q;
					endcase
				end else begin
					push_word.is_q = wsel_reg;
					push_word.data = wsel_reg ? res_reg.q : res_reg.i;
				end
				if (fifo_in_ready) begin
					if (shift_en_reg) begin
						if (!sync_ok) step_next = step_reg + 2'h1;
						st_next = ddcf_pkg::DDCF_ST_IDLE;
					end else if (wsel_reg) begin
						st_next = ddcf_pkg::DDCF_ST_IDLE;
					end else begin
						wsel_next = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ddcf_pkg::DDCF_ST_IDLE;
			for (int k = 0; k < HB_N; k++) hb_line_reg[k] <= '0;
			for (int k = 0; k < FIR_N; k++) fir_line_reg[k] <= '0;
			byp_reg <= '0;
			res_reg <= '0;
			cnt_reg <= 1'b0;
			wsel_reg <= 1'b0;
			step_reg <= 2'h0;
		end else if (ce) begin
			st_reg <= st_next;
			hb_line_reg <= hb_line_next;
			fir_line_reg <= fir_line_next;
			byp_reg <= byp_next;
			res_reg <= res_next;
			cnt_reg <= cnt_next;
			wsel_reg <= wsel_next;
			step_reg <= step_next;
		end
	end

	ddcf_fifo #(
		.W($bits(ddcf_pkg::ddcf_word_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(out_ready),
		.out_data(out_word)
	);
	assign out_valid = fifo_out_valid;

	a_once_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && once_reg && sync_ok && !reg_we |=> !armed_reg && !sync_ok)
		else $error("one-shot strobe not consumed");
	a_write_arm: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && reg_we && reg_addr == `DDCF_A_SYNC |=> armed_reg)
		else $error("register write did not arm strobe");
	a_sync_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && sync_ok |=> cnt_reg == ($past(accept) ? $past(dec_ph_reg) : !$past(dec_ph_reg)))
		else $error("strobe did not restart decimation phase");
	a_dec_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && accept && !cnt_cur |=> st_reg == ddcf_pkg::DDCF_ST_IDLE)
		else $error("skipped sample produced output");
	a_fir_feed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && st_reg == ddcf_pkg::DDCF_ST_HB && fir_en_reg
		|=> fir_line_reg[0] == $past(hb_val) && st_reg == ddcf_pkg::DDCF_ST_FIR)
		else $error("FIR fed from other than half-band");
	a_fir_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && st_reg == ddcf_pkg::DDCF_ST_FIR && !fir_en_reg |=> res_reg == $past(byp_reg))
		else $error("bypass did not pass sample");
	a_real_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fifo_in_valid && shift_en_reg && step_reg == 2'h3 |-> push_word.data == res_reg.q)
		else $error("final shift word wrong");
	a_interleave: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && fifo_in_valid && fifo_in_ready && !shift_en_reg && !wsel_reg
		|=> fifo_in_valid && wsel_reg && push_word.is_q)
		else $error("Q did not follow I");
endmodule : ddcf_top

// ### ddcf_sink.sv
`timescale 1ns/1ps

module ddcf_sink (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Slow mode: refuse one cycle in three
	input wire logic stall,
	// Output stream of the block
	input wire logic out_valid,
	output logic out_ready,
	input wire ddcf_pkg::ddcf_word_s out_word
);
	logic [1:0] cnt_reg;
	ddcf_pkg::ddcf_word_s got[$];

	assign out_ready = !stall || (cnt_reg != 2'h0);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
		end else begin
			cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
			if (out_valid && out_ready) begin
				got.push_back(out_word);
			end
		end
	end
endmodule : ddcf_sink

// ### testbench.sv
`timescale 1ns/1ps
`include "ddcf_map.svh"

module testbench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [8:0] reg_addr = 9'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [7:0] reg_rdata;
	logic in_valid = 1'b0;
	logic in_ready;
	ddcf_pkg::ddcf_iq_s in_iq = '0;
	logic sync_in = 1'b0;
	logic out_valid;
	logic out_ready;
	logic stall = 1'b0;
	ddcf_pkg::ddcf_word_s out_word;
	int n_mismatch = 0;
	int checked = 0;
	logic rdy;
	logic rdy0;
	logic [7:0] d;
	// Steady I=2000, Q=1000 after both stages; real sequence I, -Q, -I, Q
	logic [16:0] real_exp [4] = '{17'h007D0, 17'h0FC18, 17'h0F830, 17'h003E8};
	logic [8:0] amap [4] = '{`DDCF_A_SYNC, `DDCF_A_FIR, `DDCF_A_HB, `DDCF_A_SHIFT};

	always #5 clk_sys = ~clk_sys;

	ddcf_top #(.DATA_W(16), .FIFO_DEPTH(`DDCF_FIFO_DEPTH)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata),
		.in_valid(in_valid), .in_ready(in_ready), .in_iq(in_iq),
		.sync_in(sync_in),
		.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
	);

	ddcf_sink sink_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
		.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
	);

	task chk(input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask : wr

	task rd(input logic [8:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// One sample of I=1000, Q=500; rdy is in_ready the cycle after acceptance
	task send(input logic s);
		int k;
		@(posedge clk_sys);
		in_iq <= '{i: 16'sh03E8, q: 16'sh01F4};
		in_valid <= 1'b1;
		sync_in <= s;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (in_ready !== 1'b1 && k < 100);
		if (k >= 100) begin
			n_mismatch++;
			$display("[FAIL] %0t input never accepted", $time);
		end
		@(posedge clk_sys);
		in_valid <= 1'b0;
		sync_in <= 1'b0;
		@(negedge clk_sys);
		rdy = in_ready;
	endtask : send

	task run(input int n);
		int k;
		sink_u.got.delete();
		for (int i = 0; i < n; i++) begin
			send(i == 0);
			if (i == 0) rdy0 = rdy;
		end
		k = 0;
		while ((out_valid !== 1'b0 || in_ready !== 1'b1) && k < 200) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 200) begin
			n_mismatch++;
			$display("[FAIL] %0t output never drained", $time);
		end
	endtask : run

	task t_regs;
		foreach (amap[k]) begin
			rd(amap[k]);
			chk({9'h000, d}, 17'h00000);
		end
		wr(`DDCF_A_FIR, 8'h01);
		rd(`DDCF_A_FIR);
		chk({9'h000, d}, 17'h00001);
		wr(9'h1FF, 8'hAA);
		rd(9'h1FF);
		chk({9'h000, d}, 17'h00000);
		// Frozen block must drop a write
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(`DDCF_A_FIR, 8'h00);
		ce <= 1'b1;
		rd(`DDCF_A_FIR);
		chk({9'h000, d}, 17'h00001);
		wr(`DDCF_A_FIR, 8'h00);
	endtask : t_regs

	task t_bypass;
		wr(`DDCF_A_SYNC, 8'h20);
		run(40);
		chk({16'h0000, rdy0}, 17'h00000);
		chk(17'(sink_u.got.size()), 17'h00028);
		chk(sink_u.got[38], 17'h007D0);
		chk(sink_u.got[39], 17'h103E8);
	endtask : t_bypass

	task t_fir;
		wr(`DDCF_A_FIR, 8'h01);
		stall <= 1'b1;
		run(160);
		chk(17'(sink_u.got.size()), 17'h000A0);
		foreach (sink_u.got[k]) chk({16'h0000, sink_u.got[k].is_q}, 17'(k % 2));
		chk(sink_u.got[158], 17'h007D0);
		chk(sink_u.got[159], 17'h103E8);
	endtask : t_fir

	task t_real;
		wr(`DDCF_A_SHIFT, 8'h01);
		run(16);
		chk(17'(sink_u.got.size()), 17'h00008);
		foreach (sink_u.got[k]) chk({1'b0, sink_u.got[k].data}, real_exp[k % 4]);
		stall <= 1'b0;
	endtask : t_real

	task t_sync;
		wr(`DDCF_A_SHIFT, 8'h00);
		wr(`DDCF_A_HB, 8'h08);
		wr(`DDCF_A_SYNC, 8'h60);
		rd(`DDCF_A_STAT);
		chk({16'h0000, d[0]}, 17'h00001);
		send(1'b1);
		chk({16'h0000, rdy}, 17'h00001);
		rd(`DDCF_A_STAT);
		chk({16'h0000, d[0]}, 17'h00000);
		// Second strobe ignored, so this sample closes the pair
		send(1'b1);
		chk({16'h0000, rdy}, 17'h00000);
		run(0);
		wr(`DDCF_A_SYNC, 8'h20);
		send(1'b1);
		chk({16'h0000, rdy}, 17'h00001);
		send(1'b1);
		chk({16'h0000, rdy}, 17'h00001);
		run(0);
	endtask : t_sync

	task print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_bypass();
		t_fir();
		t_real();
		t_sync();
		print_verdict();
	end

	// About 850 cycles expected; allow over twenty times that
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule : testbench
